// File: rtl/scan_seq_consts.svh
`ifndef SCAN_SEQ_CONSTS_SVH
`define SCAN_SEQ_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_MODE 8'h04
`define REG_STATUS 8'h08
`define REG_LIST_ADDR 8'h0C
`define REG_LIST_DATA 8'h10
`define REG_LIST_LEN 8'h14
`define REG_GAP 8'h18
`define REG_PRE 8'h1C
`define REG_ANA 8'h20
`define REG_DIG 8'h24
`define REG_PAT 8'h28
`define REG_CTR 8'h2C
`define REG_CTR_LIM 8'h30
`define REG_TRIG_POS 8'h34
`define REG_SAMP_CNT 8'h38
`define CFG_RESET 32'h0000_0000
`define MASK_MODE 32'h0000_01FF
`define MASK_LIST 32'h0000_3FFF
`define MASK_GAP 32'h01FF_FFFF
`define MASK_ANA 32'h007F_FFFF
`define MASK_NIB 32'h0000_000F
`define MASK_ENT 32'h0001_FFFF
`define CTRL_ARM 0
`define CTRL_HALT 1
`define CTRL_SWTRIG 2
`define MODE_ACQ_LSB 0
`define MODE_START_LSB 3
`define MODE_STOP_LSB 6
`define ANA_LEVEL_LSB 0
`define ANA_CHAN_LSB 12
`define ANA_FALL_BIT 22
`define DIG_MODE_LSB 0
`define DIG_PSEL_LSB 2
`define PAT_MASK_LSB 16
`define CTR_SEL_LSB 0
`define CTR_CMP_LSB 2
`define LIM_HI_LSB 16
`define ENT_CHAN_LSB 0
`define ENT_GAIN_LSB 10
`define ENT_KIND_LSB 13
`define ENT_IVL_LSB 15
`define GAIN_CODE_MAX 3'h6
`define LIST_DEPTH 16384
`define GAP_MAX_MS 32'd21600000
`define CLK_PERIOD_PS 5000
`define IVL_SHORT_US 5
`define IVL_MID_US 10
`define IVL_LONG_US 1000
`define GAP_UNIT_MS 1
`define SHORT_IVL_CYC (`IVL_SHORT_US * 1000000 / `CLK_PERIOD_PS)
`define MID_IVL_CYC (`IVL_MID_US * 1000000 / `CLK_PERIOD_PS)
`define LONG_IVL_CYC (`IVL_LONG_US * 1000000 / `CLK_PERIOD_PS)
`define MS_CYC (`GAP_UNIT_MS * 1000000000 / `CLK_PERIOD_PS)
`endif

// File: rtl/scan_seq_pkg.sv
package scan_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_WAIT = 4'h2, ST_PRE = 4'h4, ST_RUN = 4'h8
  } state_type;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_SW = 3'h1, SRC_ANA = 3'h2, SRC_DIG = 3'h3,
    SRC_PAT = 3'h4, SRC_CTR = 3'h5
  } src_type;
  typedef enum logic [2:0] {
    ACQ_STOP = 3'h0, ACQ_FIX_STOP = 3'h1, ACQ_INF = 3'h2,
    ACQ_FIX_INF = 3'h3, ACQ_VAR_STOP = 3'h4, ACQ_VAR_INF = 3'h5
  } acq_type;
  typedef enum logic [1:0] {
    KIND_ANALOG = 2'h0, KIND_DIGITAL = 2'h1, KIND_COUNTER = 2'h2
  } kind_type;
endpackage : scan_seq_pkg

// File: rtl/scan_sequencer_trigger_unit.sv
`timescale 1ns/1ps
`include "scan_seq_consts.svh"
// What this block does
// RQ1: Scan list memory of 16384 entries, each a channel and range.
// RQ2: Each entry selects its own interval of 5, 10 or 1000 us.
// RQ3: Programmable gap between group starts, zero to six hours.
// RQ4: Entries may name digital or counter inputs beside analog ones.
// RQ5: Entry types and intervals mix freely inside one group.
// RQ6: Analog comparator crossing, rising or falling, triggers within 5 us.
// RQ7: External logic trigger fires on high, low, rising or falling.
// RQ8: Masked pattern compare on a chosen digital port starts scanning.
// RQ9: Counter trigger on reach, exceed or within a level window.
// RQ10: Host must use software trigger with any pre-trigger mode.
// RQ11: No pre-trigger: store from start trigger until stop event.
// RQ12: Fixed pre-trigger: take set count first, run until stop event.
// RQ13: Infinite post-trigger: run from trigger until host halt.
// RQ14: Fixed pre-trigger infinite: take count, then run until halt.
// RQ15: Variable pre-trigger: trigger accepted before count is met.
// RQ16: Stop source chosen independently of the start source.
// RQ17: Aggregate scanning up to 200 kHz across all input kinds.
// RQ18: Scan period is the sum of the entry intervals.
// RQ19: Analog entries select gain 1, 2, 4, 8, 16, 32 or 64.
// RQ20: Channel field addresses up to 896 channels.
// RQ21: Forty digital lines: three 8-bit ports and one 16-bit port.
// RQ22: Pre-trigger samples go to a circular buffer; trigger position kept.
module scan_sequencer_trigger_unit #(
  parameter int LONG_IVL_CYCLES = `LONG_IVL_CYC,
  parameter int CYCLES_PER_MS = `MS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ana_cmp_in,
  input wire logic ext_logic_trigger_in,
  input wire logic [7:0] dig_port_a,
  input wire logic [7:0] dig_port_b,
  input wire logic [7:0] dig_port_c,
  input wire logic [15:0] dig_port_d,
  input wire logic [15:0] ctr_val0,
  input wire logic [15:0] ctr_val1,
  input wire logic [15:0] ctr_val2,
  input wire logic [15:0] ctr_val3,
  output logic [9:0] ana_trig_chan,
  output logic [11:0] ana_trig_level,
  output logic samp_strobe,
  output logic [9:0] samp_chan,
  output logic [2:0] samp_gain,
  output logic [1:0] samp_kind,
  output logic samp_store,
  output logic [13:0] samp_addr
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [17:0] ivl_cyc(input logic [1:0] sel);
    logic [17:0] r;
    r = 18'(LONG_IVL_CYCLES);
    if (sel == 2'h0) begin
      r = 18'(`SHORT_IVL_CYC);
    end else if (sel == 2'h1) begin
      r = 18'(`MID_IVL_CYC);
    end
    return r;
  endfunction : ivl_cyc

  function automatic logic pick(input logic [5:0] hits, input logic [2:0] src);
    return (src <= scan_seq_pkg::SRC_CTR) ? hits[src] : 1'b0;
  endfunction : pick

  logic [16:0] scan_mem [`LIST_DEPTH];
  logic [31:0] cfg_mode, cfg_len, cfg_gap, cfg_pre, cfg_ana, cfg_dig, cfg_pat;
  logic [31:0] cfg_ctr, cfg_lim;
  logic [13:0] list_addr;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have, w_have;
  logic arm_p, halt_p, sw_p;
  scan_seq_pkg::state_type state;
  logic triggered, stopped;
  logic [13:0] trig_pos, wr_addr;
  logic [31:0] samp_cnt;
  logic [1:0] ana_sync, dig_sync;
  logic [39:0] port_meta, port_sync;
  logic ana_prev, dig_prev;
  logic [13:0] idx;
  logic [16:0] ent;
  logic [17:0] cnt;
  logic eng_first, eng_wrap;
  logic [42:0] grp_cnt;

  wire wr_en = aw_have && w_have && !s_axi_bvalid;
  wire [31:0] wr_val = merge(32'h0000_0000, w_data, w_strb);
  wire active = (state == scan_seq_pkg::ST_PRE) || (state == scan_seq_pkg::ST_RUN);
  wire [2:0] acq = cfg_mode[`MODE_ACQ_LSB +: 3];
  wire [2:0] start_src = cfg_mode[`MODE_START_LSB +: 3];
  wire [2:0] stop_src = cfg_mode[`MODE_STOP_LSB +: 3];
  wire fixed_pre = (acq == scan_seq_pkg::ACQ_FIX_STOP) || (acq == scan_seq_pkg::ACQ_FIX_INF);
  wire var_pre = (acq == scan_seq_pkg::ACQ_VAR_STOP) || (acq == scan_seq_pkg::ACQ_VAR_INF);
  wire inf_mode = (acq == scan_seq_pkg::ACQ_INF) || (acq == scan_seq_pkg::ACQ_FIX_INF) ||
                  (acq == scan_seq_pkg::ACQ_VAR_INF);
  wire [42:0] gap_cyc = 43'(cfg_gap[24:0]) * 43'(CYCLES_PER_MS);
  wire last = (idx == cfg_len[13:0]);
  wire fire = active && (eng_first || (cnt == 18'h0 && (!eng_wrap || grp_cnt >= gap_cyc)));

  assign ana_trig_chan = cfg_ana[`ANA_CHAN_LSB +: 10];
  assign ana_trig_level = cfg_ana[`ANA_LEVEL_LSB +: 12];

  // Write channel: address and data are taken independently, in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `REG_SAMP_CNT || aw_addr[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers; reserved bits are masked so they read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {cfg_mode, cfg_len, cfg_gap, cfg_pre} <= {4{`CFG_RESET}};
      {cfg_ana, cfg_dig, cfg_pat, cfg_ctr, cfg_lim} <= {5{`CFG_RESET}};
      list_addr <= 14'h0000;
      {arm_p, halt_p, sw_p} <= 3'h0;
    end else begin
      {arm_p, halt_p, sw_p} <= 3'h0;
      if (wr_en) begin
        case (aw_addr)
          `REG_CTRL: begin
            arm_p <= wr_val[`CTRL_ARM];
            halt_p <= wr_val[`CTRL_HALT];
            sw_p <= wr_val[`CTRL_SWTRIG];
          end
          `REG_MODE: cfg_mode <= merge(cfg_mode, w_data, w_strb) & `MASK_MODE; // RQ16
          `REG_LIST_ADDR: list_addr <= 14'(merge(32'(list_addr), w_data, w_strb));
          `REG_LIST_DATA: list_addr <= list_addr + 14'h0001;
          `REG_LIST_LEN: cfg_len <= merge(cfg_len, w_data, w_strb) & `MASK_LIST;
          `REG_GAP: begin
            // Six hours is the longest gap; larger requests are clamped
            if ((merge(cfg_gap, w_data, w_strb) & `MASK_GAP) > `GAP_MAX_MS) begin
              cfg_gap <= `GAP_MAX_MS; // RQ3
            end else begin
              cfg_gap <= merge(cfg_gap, w_data, w_strb) & `MASK_GAP;
            end
          end
          `REG_PRE: cfg_pre <= merge(cfg_pre, w_data, w_strb);
          `REG_ANA: cfg_ana <= merge(cfg_ana, w_data, w_strb) & `MASK_ANA;
          `REG_DIG: cfg_dig <= merge(cfg_dig, w_data, w_strb) & `MASK_NIB;
          `REG_PAT: cfg_pat <= merge(cfg_pat, w_data, w_strb);
          `REG_CTR: cfg_ctr <= merge(cfg_ctr, w_data, w_strb) & `MASK_NIB;
          `REG_CTR_LIM: cfg_lim <= merge(cfg_lim, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  // Scan list storage; partial strobes are not honoured on list words
  always_ff @(posedge ref_clk) begin
    if (wr_en && aw_addr == `REG_LIST_DATA) begin
      scan_mem[list_addr] <= {4'h0,
                              (w_data[`ENT_GAIN_LSB +: 3] > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX :
                              w_data[`ENT_GAIN_LSB +: 3], w_data[9:0]} |
                             (w_data[16:0] & 17'h1_E000); // RQ1 RQ19 RQ20 RQ4
    end
    ent <= scan_mem[idx];
  end

  // Read channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OK;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= 32'h0000_0000;
        `REG_MODE: s_axi_rdata <= cfg_mode;
        `REG_STATUS: s_axi_rdata <= {26'h0, stopped, triggered, state};
        `REG_LIST_ADDR: s_axi_rdata <= {18'h0, list_addr};
        `REG_LIST_DATA: s_axi_rdata <= {15'h0, scan_mem[list_addr]};
        `REG_LIST_LEN: s_axi_rdata <= cfg_len;
        `REG_GAP: s_axi_rdata <= cfg_gap;
        `REG_PRE: s_axi_rdata <= cfg_pre;
        `REG_ANA: s_axi_rdata <= cfg_ana;
        `REG_DIG: s_axi_rdata <= cfg_dig;
        `REG_PAT: s_axi_rdata <= cfg_pat;
        `REG_CTR: s_axi_rdata <= cfg_ctr;
        `REG_CTR_LIM: s_axi_rdata <= cfg_lim;
        `REG_TRIG_POS: s_axi_rdata <= {18'h0, trig_pos};
        `REG_SAMP_CNT: s_axi_rdata <= samp_cnt;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pin synchronisers; two stages cost 10 ns of the 5 us latency budget
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {ana_sync, dig_sync, ana_prev, dig_prev} <= 6'h00;
      port_meta <= 40'h00_0000_0000;
      port_sync <= 40'h00_0000_0000;
    end else begin
      ana_sync <= {ana_sync[0], ana_cmp_in};
      dig_sync <= {dig_sync[0], ext_logic_trigger_in};
      ana_prev <= ana_sync[1];
      dig_prev <= dig_sync[1];
      port_meta <= {dig_port_d, dig_port_c, dig_port_b, dig_port_a}; // RQ21
      port_sync <= port_meta;
    end
  end

  logic ana_hit, dig_hit, pat_hit, ctr_hit;
  logic [15:0] pat_port, ctr_sel;
  logic [1:0] dmode;
  always_comb begin
    ana_hit = cfg_ana[`ANA_FALL_BIT] ? (ana_prev && !ana_sync[1]) :
              (!ana_prev && ana_sync[1]); // RQ6
    dmode = cfg_dig[`DIG_MODE_LSB +: 2];
    case (dmode)
      2'h0: dig_hit = dig_sync[1]; // RQ7
      2'h1: dig_hit = !dig_sync[1];
      2'h2: dig_hit = dig_sync[1] && !dig_prev;
      default: dig_hit = !dig_sync[1] && dig_prev;
    endcase
    case (cfg_dig[`DIG_PSEL_LSB +: 2])
      2'h0: pat_port = {8'h00, port_sync[7:0]};
      2'h1: pat_port = {8'h00, port_sync[15:8]};
      2'h2: pat_port = {8'h00, port_sync[23:16]};
      default: pat_port = port_sync[39:24];
    endcase
    // Mask bits set to one are ignored in the compare
    pat_hit = ((pat_port ^ cfg_pat[15:0]) & ~cfg_pat[`PAT_MASK_LSB +: 16]) == 16'h0000; // RQ8
    case (cfg_ctr[`CTR_SEL_LSB +: 2])
      2'h0: ctr_sel = ctr_val0; // RQ9
      2'h1: ctr_sel = ctr_val1;
      2'h2: ctr_sel = ctr_val2;
      default: ctr_sel = ctr_val3;
    endcase
    case (cfg_ctr[`CTR_CMP_LSB +: 2])
      2'h0: ctr_hit = ctr_sel == cfg_lim[15:0];
      2'h1: ctr_hit = ctr_sel > cfg_lim[15:0];
      2'h2: ctr_hit = ctr_sel >= cfg_lim[15:0] && ctr_sel <= cfg_lim[`LIM_HI_LSB +: 16];
      default: ctr_hit = 1'b0;
    endcase
  end

  wire [5:0] hits = {ctr_hit, pat_hit, dig_hit, ana_hit, sw_p, 1'b0};
  wire start_hit = pick(hits, start_src);
  wire stop_hit = pick(hits, stop_src); // RQ16
  // Fixed modes hold off the trigger until the pre-trigger count is met
  wire pre_ok = var_pre || (fixed_pre && samp_cnt >= cfg_pre); // RQ12 RQ14 RQ15
  // RQ10: pre-trigger modes assume the host picked the software source

  // Acquisition state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= scan_seq_pkg::ST_IDLE;
      triggered <= 1'b0;
      stopped <= 1'b0;
      trig_pos <= 14'h0000;
    end else begin
      case (state)
        scan_seq_pkg::ST_IDLE: begin
          if (arm_p) begin
            triggered <= 1'b0;
            stopped <= 1'b0;
            state <= (fixed_pre || var_pre) ? scan_seq_pkg::ST_PRE : scan_seq_pkg::ST_WAIT;
          end
        end
        scan_seq_pkg::ST_WAIT: begin
          if (halt_p) begin
            state <= scan_seq_pkg::ST_IDLE;
          end else if (start_hit) begin
            state <= scan_seq_pkg::ST_RUN; // RQ11 RQ13
            triggered <= 1'b1;
            trig_pos <= wr_addr;
          end
        end
        scan_seq_pkg::ST_PRE: begin
          if (halt_p) begin
            state <= scan_seq_pkg::ST_IDLE;
          end else if (start_hit && pre_ok) begin
            state <= scan_seq_pkg::ST_RUN;
            triggered <= 1'b1;
            trig_pos <= wr_addr; // RQ22
          end
        end
        scan_seq_pkg::ST_RUN: begin
          if (halt_p || (!inf_mode && stop_hit)) begin
            state <= scan_seq_pkg::ST_IDLE; // RQ11 RQ12 RQ13 RQ14
            stopped <= 1'b1;
          end
        end
        default: state <= scan_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Scan engine: each entry holds for its own interval, groups spaced by the gap
  always_ff @(posedge ref_clk) begin
    if (rst || !active) begin
      idx <= 14'h0000;
      cnt <= 18'h0;
      eng_first <= 1'b1;
      eng_wrap <= 1'b0;
      grp_cnt <= 43'h0;
    end else begin
      grp_cnt <= grp_cnt + 43'h1;
      if (fire) begin
        cnt <= ivl_cyc(ent[`ENT_IVL_LSB +: 2]) - 18'h1; // RQ2 RQ5 RQ18 RQ17
        eng_first <= 1'b0;
        eng_wrap <= 1'b0;
        if (eng_first || eng_wrap) begin
          grp_cnt <= 43'h1; // RQ3
        end
      end else if (cnt != 18'h0) begin
        cnt <= cnt - 18'h1;
        // Step two cycles early so the registered list read is ready at fire
        if (cnt == 18'h2) begin
          idx <= last ? 14'h0000 : idx + 14'h0001;
          eng_wrap <= last;
        end
      end
    end
  end

  // Sample requests; the write address wraps, so pre-trigger data is circular
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      samp_strobe <= 1'b0;
      samp_chan <= 10'h000;
      samp_gain <= 3'h0;
      samp_kind <= 2'h0;
      samp_store <= 1'b0;
      samp_addr <= 14'h0000;
      wr_addr <= 14'h0000;
      samp_cnt <= 32'h0000_0000;
    end else begin
      samp_strobe <= fire;
      if (arm_p && state == scan_seq_pkg::ST_IDLE) begin
        wr_addr <= 14'h0000;
        samp_cnt <= 32'h0000_0000;
      end else if (fire) begin
        samp_chan <= ent[`ENT_CHAN_LSB +: 10]; // RQ4 RQ20
        samp_gain <= ent[`ENT_GAIN_LSB +: 3]; // RQ19
        samp_kind <= ent[`ENT_KIND_LSB +: 2];
        samp_store <= 1'b1;
        samp_addr <= wr_addr;
        wr_addr <= wr_addr + 14'h0001; // RQ22
        if (samp_cnt != 32'hFFFF_FFFF) begin
          samp_cnt <= samp_cnt + 32'h0000_0001;
        end
      end
    end
  end

  logic [19:0] since_fire;
  logic [17:0] prev_ivl;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      since_fire <= 20'h0;
      prev_ivl <= 18'h0;
    end else if (fire) begin
      since_fire <= 20'h1;
      prev_ivl <= ivl_cyc(ent[`ENT_IVL_LSB +: 2]);
    end else if (since_fire != 20'hF_FFFF) begin
      since_fire <= since_fire + 20'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  entry_interval_a: assert property (fire && !eng_first && !eng_wrap |->
    20'(prev_ivl) == since_fire) else $error("entry interval wrong"); // RQ2
  group_gap_a: assert property (fire && eng_wrap |-> grp_cnt >= gap_cyc)
    else $error("group started before gap"); // RQ3
  ana_start_a: assert property (state == scan_seq_pkg::ST_WAIT && !halt_p &&
    start_src == scan_seq_pkg::SRC_ANA && ana_hit |=> state == scan_seq_pkg::ST_RUN)
    else $error("analog trigger missed"); // RQ6
  dig_start_a: assert property (state == scan_seq_pkg::ST_WAIT && !halt_p &&
    start_src == scan_seq_pkg::SRC_DIG && dig_hit |=> triggered)
    else $error("logic trigger missed"); // RQ7
  pat_wait_a: assert property (state == scan_seq_pkg::ST_WAIT &&
    start_src == scan_seq_pkg::SRC_PAT && !pat_hit |=> state != scan_seq_pkg::ST_RUN)
    else $error("pattern started early"); // RQ8
  stop_event_a: assert property (state == scan_seq_pkg::ST_RUN && !inf_mode && stop_hit
    |=> state == scan_seq_pkg::ST_IDLE && stopped) else $error("stop event ignored"); // RQ11
  inf_run_a: assert property (state == scan_seq_pkg::ST_RUN && inf_mode && !halt_p
    |=> state == scan_seq_pkg::ST_RUN) else $error("infinite run ended"); // RQ13
  pre_hold_a: assert property (state == scan_seq_pkg::ST_PRE && fixed_pre &&
    samp_cnt < cfg_pre |=> !triggered) else $error("fixed pre count skipped"); // RQ12
  trig_mark_a: assert property ($rose(triggered) |-> trig_pos == $past(wr_addr))
    else $error("trigger position wrong"); // RQ22
  strobe_store_a: assert property (fire |=> samp_strobe && samp_store ##1 !samp_strobe)
    else $error("sample strobe wrong"); // RQ17
  pre_run_c: cover property (state == scan_seq_pkg::ST_PRE ##1 state == scan_seq_pkg::ST_RUN);
  wrap_c: cover property (fire && eng_wrap);
  stop_c: cover property ($rose(stopped));
endmodule : scan_sequencer_trigger_unit

// File: testbench/input_side_model.sv
`timescale 1ns/1ps
// Comparator, logic line, port and counter follow one event from the bench
module input_side_model (
  input wire logic fire,
  output logic ana_cmp_in,
  output logic ext_logic_trigger_in,
  output logic [7:0] dig_port_a,
  output logic [15:0] ctr_val0
);
  assign ana_cmp_in = fire;
  assign ext_logic_trigger_in = fire;
  // Idle pattern is the inverse, so masked compare must really miss
  assign dig_port_a = fire ? 8'h5A : 8'hA5;
  assign ctr_val0 = fire ? 16'h0020 : 16'h0000;
endmodule : input_side_model

// File: testbench/test_scan_sequencer_trigger_unit.sv
`timescale 1ns/1ps
`include "scan_seq_consts.svh"
module test_scan_sequencer_trigger_unit;
  logic ref_clk = 1'b0, rst = 1'b1, fire = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic ana_cmp_in, ext_logic_trigger_in, samp_strobe, samp_store;
  logic [7:0] dig_port_a;
  logic [15:0] ctr_val0;
  logic [9:0] ana_trig_chan, samp_chan;
  logic [11:0] ana_trig_level;
  logic [2:0] samp_gain;
  logic [1:0] samp_kind;
  logic [13:0] samp_addr;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  int st_t[$];
  logic [29:0] st_v[$];
  localparam logic [7:0] RA [6] = '{8'h04, 8'h18, 8'h20, 8'h14, 8'h3C, 8'h02};
  localparam logic [31:0] RX [6] = '{32'h0000_01FF, 32'h0149_9700, 32'h007F_FFFF,
    32'h0000_3FFF, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] RS [6] = '{0, 0, 0, 0, 2, 2};
  localparam logic [31:0] ENT [3] = '{32'h0000_1C05, 32'h0000_A002, 32'h0001_4001};
  localparam logic [29:0] SX [3] = '{{1'b1, 14'd0, 2'd0, 3'd6, 10'd5},
    {1'b1, 14'd1, 2'd1, 3'd0, 10'd2}, {1'b1, 14'd2, 2'd2, 3'd0, 10'd1}};

  localparam int MS_CYCLES = 50;
  scan_sequencer_trigger_unit #(.LONG_IVL_CYCLES(20), .CYCLES_PER_MS(MS_CYCLES)) uut (
    .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ana_cmp_in, .ext_logic_trigger_in,
    .dig_port_a, .dig_port_b(dig_port_a), .dig_port_c(dig_port_a),
    .dig_port_d({dig_port_a, dig_port_a}), .ctr_val0, .ctr_val1(ctr_val0),
    .ctr_val2(ctr_val0), .ctr_val3(ctr_val0), .ana_trig_chan, .ana_trig_level,
    .samp_strobe, .samp_chan, .samp_gain, .samp_kind, .samp_store, .samp_addr);
  input_side_model far (.fire, .ana_cmp_in, .ext_logic_trigger_in, .dig_port_a, .ctr_val0);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (samp_strobe === 1'b1) begin
      st_t.push_back(cyc);
      st_v.push_back({samp_store, samp_addr, samp_kind, samp_gain, samp_chan});
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic results();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // bready stays high, so back-to-back writes never touch it twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    resp = s_axi_bresp;
    if (n >= 100) chk(32'h0, 32'h1);
    if (n >= 100) results();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 100) chk(32'h0, 32'h1);
    if (n >= 100) results();
  endtask : rd

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`REG_STATUS);
    chk(rdat, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(RA[i], 32'hFFFF_FFFF);
      chk(32'(resp), RS[i]);
      rd(RA[i]);
      chk(rdat, RX[i]);
      chk(32'(resp), RS[i]);
    end
    chk({10'h0, ana_trig_chan, ana_trig_level}, 32'h003F_FFFF);
    wr(`REG_LIST_ADDR, 32'h0);
    for (int i = 0; i < 3; i++) wr(`REG_LIST_DATA, ENT[i]);
    wr(`REG_LIST_LEN, 32'h2);
    wr(`REG_LIST_ADDR, 32'h0);
    rd(`REG_LIST_DATA);
    chk(rdat, 32'h0000_1805);
    wr(`REG_LIST_ADDR, 32'h1);
    rd(`REG_LIST_DATA);
    chk(rdat, ENT[1]);
    // Infinite post-trigger, software start: mixed entries, next group paced by the gap
    wr(`REG_GAP, 32'd100);
    wr(`REG_MODE, 32'h0000_000A);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CTRL, 32'h4);
    for (int n = 0; n < 8000 && st_t.size() < 4; n++) @(posedge ref_clk);
    chk(st_t.size(), 4);
    if (st_t.size() < 4) results();
    chk(st_t[3] - st_t[0], 100 * MS_CYCLES);
    chk(32'(st_v[3]), 32'(SX[0]) | 32'h0001_8000);
    for (int i = 0; i < 3; i++) chk(32'(st_v[i]), 32'(SX[i]));
    chk(st_t[1] - st_t[0], `SHORT_IVL_CYC);
    chk(st_t[2] - st_t[1], `MID_IVL_CYC);
    rd(`REG_STATUS);
    chk(rdat, 32'h18);
    wr(`REG_CTRL, 32'h2);
    rd(`REG_STATUS);
    chk(rdat & 32'hF, 32'h1);
    wr(`REG_ANA, 32'h0);
    wr(`REG_DIG, 32'h0);
    wr(`REG_PAT, 32'hFF00_005A);
    wr(`REG_CTR, 32'h4);
    wr(`REG_CTR_LIM, 32'h0000_0010);
    for (int s = 1; s < 6; s++) begin
      wr(`REG_MODE, 32'h2 | (32'(s) << 3));
      wr(`REG_CTRL, 32'h1);
      rd(`REG_STATUS);
      chk(rdat, 32'h2);
      if (s == 1) wr(`REG_CTRL, 32'h4);
      else fire <= 1'b1;
      repeat (20) @(posedge ref_clk);
      rd(`REG_STATUS);
      chk(rdat, 32'h18);
      wr(`REG_CTRL, 32'h2);
      fire <= 1'b0;
    end
    // Software start, logic-line stop
    wr(`REG_MODE, 32'h0000_00C8);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CTRL, 32'h4);
    rd(`REG_STATUS);
    chk(rdat, 32'h18);
    fire <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rd(`REG_STATUS);
    chk(rdat, 32'h31);
    fire <= 1'b0;
    // Early trigger: fixed pre-trigger holds, variable accepts
    wr(`REG_PRE, 32'h100);
    wr(`REG_MODE, 32'h0000_0009);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CTRL, 32'h4);
    rd(`REG_STATUS);
    chk(rdat & 32'hF, 32'h4);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_MODE, 32'h0000_000C);
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CTRL, 32'h4);
    rd(`REG_STATUS);
    chk(rdat, 32'h18);
    results();
  end
endmodule : test_scan_sequencer_trigger_unit
